// ### common/cct_pkg.sv
// constants, field layout and types of the capture/compare timer
package cct_pkg;

  // ==========================================================
  // register byte offsets on the bus
  localparam logic [5:0] OFF_CTRL0 = 6'h00;
  localparam logic [5:0] OFF_CTRL1 = 6'h04;
  localparam logic [5:0] OFF_CNT_LO = 6'h08;
  localparam logic [5:0] OFF_CNT_HI = 6'h0c;
  localparam logic [5:0] OFF_CMP_LO = 6'h10;
  localparam logic [5:0] OFF_CMP_HI = 6'h14;
  localparam logic [5:0] OFF_CAP_LO = 6'h18;
  localparam logic [5:0] OFF_CAP_HI = 6'h1c;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h20;
  localparam logic [5:0] OFF_IRQ_EN = 6'h24;
  localparam logic [5:0] OFF_IRQ_CLR = 6'h28;

  // ==========================================================
  // control register 0 fields
  localparam int unsigned C0_SRC_LSB = 0;
  localparam int unsigned C0_ON = 3;
  localparam int unsigned C0_CLK_LSB = 4;
  localparam int unsigned C0_PAUSE = 7;
  localparam logic [7:0] C0_MASK = 8'hfb;
  // control register 1 fields
  localparam int unsigned C1_CMPCLR = 0;
  localparam int unsigned C1_CAPTURE_AUTO_CLEAR = 1;
  localparam int unsigned C1_FIL = 2;
  localparam int unsigned C1_NFS = 3;
  localparam int unsigned C1_NFT = 4;
  localparam int unsigned C1_CAPTURE_INPUT_ENABLE = 5;
  localparam int unsigned C1_EDGE_LSB = 6;

  // ==========================================================
  // interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_CMP = 1;
  localparam int unsigned IRQ_CAP = 2;

  // ==========================================================
  // reset values and counts
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [1:0] FIL_DIV_MASK = 2'h3;
  localparam int unsigned FIL_N_SHORT = 2;
  localparam int unsigned FIL_N_LONG = 4;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } cct_edge_t;

  typedef enum logic [1:0] {
    SRC_HALL_A = 2'b00,
    SRC_HALL_B = 2'b01,
    SRC_HALL_C = 2'b10,
    SRC_EXT_PIN = 2'b11
  } cct_src_t;

  localparam logic [2:0] CK_PWM = 3'b000;

endpackage

// ### core/cct_prescaler.sv
// clock-enable divider for the counter and the input filter
`timescale 1ns/1ns
`default_nettype none
module cct_prescaler
  import cct_pkg::*;
#(
  parameter int unsigned DIV_W = 7
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] clk_sel_in,
  input wire logic pwm_period_tick_in,
  output logic count_tick_out,
  output logic fil_tick_out
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic count_tick;
    logic fil_tick;
  } cct_div_state_t;

  cct_div_state_t st_r;
  cct_div_state_t st_nxt;

  // ==========================================================
  // free divider; each divided rate is one enable pulse per period, select 000 follows the pwm tick level
  always_comb begin
    logic [DIV_W-1:0] ones;
    ones = '0;
    st_nxt = st_r;
    st_nxt.div = st_r.div + 1'b1;
    for (int k = 0; k < DIV_W; k++) begin
      if (k < int'(clk_sel_in)) begin
        ones[k] = 1'b1;
      end
    end
    if (clk_sel_in == CK_PWM) begin
      st_nxt.count_tick = pwm_period_tick_in;
    end else begin
      st_nxt.count_tick = ((st_r.div & ones) == ones);
    end
    st_nxt.fil_tick = (st_r.div[1:0] == FIL_DIV_MASK);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_tick_out = st_r.count_tick;
  assign fil_tick_out = st_r.fil_tick;

endmodule
`default_nettype wire

// ### core/cct_in_filter.sv
// input synchronisers, source select, glitch filter and edge detector
`timescale 1ns/1ns
`default_nettype none
module cct_in_filter
  import cct_pkg::*;
#(
  parameter int unsigned N_SRC = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [N_SRC-1:0] pins_in,
  input wire logic [1:0] src_sel_in,
  input wire logic [1:0] edge_sel_in,
  input wire logic fil_en_in,
  input wire logic fil_slow_in,
  input wire logic fil_long_in,
  input wire logic fil_tick_in,
  output logic event_out
);

  typedef struct packed {
    logic [N_SRC-1:0] s1;
    logic [N_SRC-1:0] s2;
    logic [N_SRC-1:0] s3;
    logic [N_SRC-1:0] clean;
    logic [3:0] hist;
    logic stable;
    logic stable_d;
    logic evt;
  } cct_fil_state_t;

  cct_fil_state_t st_r;
  cct_fil_state_t st_nxt;

  // ==========================================================
  // a pin level counts only once stages two and three agree
  always_comb begin
    logic lvl;
    logic agree;
    lvl = 1'b0;
    agree = 1'b0;
    st_nxt = st_r;
    st_nxt.s1 = pins_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < N_SRC; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.clean[i] = st_r.s3[i];
      end
    end
    lvl = st_r.clean[src_sel_in];
    if (fil_en_in) begin
      if (!fil_slow_in || fil_tick_in) begin
        st_nxt.hist = {st_r.hist[2:0], lvl};
      end
      if (fil_long_in) begin
        agree = (st_r.hist == 4'h0) || (st_r.hist == 4'hf);
      end else begin
        agree = (st_r.hist[1:0] == 2'h0) || (st_r.hist[1:0] == 2'h3);
      end
      if (agree) begin
        st_nxt.stable = st_r.hist[0];
      end
    end else begin
      st_nxt.hist = {4{lvl}};
      st_nxt.stable = lvl;
    end
    st_nxt.stable_d = st_r.stable;
    case (cct_edge_t'(edge_sel_in))
      EDGE_RISE: st_nxt.evt = st_r.stable & ~st_r.stable_d;
      EDGE_FALL: st_nxt.evt = ~st_r.stable & st_r.stable_d;
      EDGE_BOTH: st_nxt.evt = st_r.stable ^ st_r.stable_d;
      default: st_nxt.evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign event_out = st_r.evt;

endmodule
`default_nettype wire

// ### core/cct_timer.sv
// capture/compare timer top with wishbone register slave
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - capture source is one of three hall inputs or the external pin
// - trigger edge is rising, falling or both
// - module-on bit enables the block; off stops the counter
// - capture input enable gates capture events separately
// - filter accepts a level after 2 or 4 equal samples
// - filter samples at system clock or system clock divided by 4
// - 16-bit up-counter readable as low and high byte
// - valid capture copies the counter into read-only capture pair
// - counter overflow sets the overflow flag
// - capture auto-clear zeroes the counter after each capture
// - 16-bit compare value held in low and high byte registers
// - counter equal to compare value sets compare-match flag
// - compare auto-clear zeroes the counter on a match
// - capture high byte is read-only bits 15 to 8, undefined at power-on
// - clock select 000 is pwm tick, 001-111 system clock over 2..128
// - on-bit rise zeroes counter; fall keeps the residual value
// - edge field: 00 off, 01 rising, 10 falling, 11 both
// - source field: 00 hall a, 01 hall b, 10 hall c, 11 pin
module cct_timer
  import cct_pkg::*;
#(
  parameter int unsigned ADR_W = 8,
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic hall_input_a_in,
  input wire logic hall_input_b_in,
  input wire logic hall_input_c_in,
  input wire logic external_capture_pin_in,
  input wire logic pwm_period_tick_in,
  output logic irq_out
);

  // ==========================================================
  // register map, byte offsets, low byte of each word used
  //   00 control 0: [1:0] source, [3] on, [6:4] clock select, [7] pause; bit 2 reads 0
  //   04 control 1: [0] compare clear, [1] capture clear, [2] filter on,
  //      [3] filter at a quarter rate, [4] four samples, [5] capture enable, [7:6] edge
  //   08/0c counter low/high, read only
  //   10/14 compare low/high, read/write
  //   18/1c capture low/high, read only
  //   20 status, read only: [0] overflow, [1] compare match, [2] capture
  //   24 interrupt enable, same layout as status
  //   28 status clear, write only, a one clears; reads 0
  //   anything else reads 0 and ignores writes
  // 16-bit values are not latched: a low/high pair read while counting may tear

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] cap;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] en;
    logic on_d;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } cct_state_t;

  cct_state_t st_r;
  cct_state_t st_nxt;

  logic count_tick;
  logic fil_tick;
  logic cap_evt;

  // word-aligned offset match, shared by read and write decode
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [5:0] off);
    hit = (adr[ADR_W-1:2] == (ADR_W-2)'(off[5:2]));
  endfunction

  // ==========================================================
  // named control fields
  logic module_on_bit;
  logic counter_pause;
  logic [2:0] counter_clock_select;
  logic [1:0] capture_source_select;
  logic [1:0] edge_select_field;
  logic capture_input_enable;
  logic input_filter_enable;
  logic filter_sample_clock_select;
  logic filter_sample_count_select;
  logic capture_auto_clear;
  logic compare_auto_clear;

  assign module_on_bit = st_r.ctrl0[C0_ON];
  assign counter_pause = st_r.ctrl0[C0_PAUSE];
  assign counter_clock_select = st_r.ctrl0[C0_CLK_LSB +: 3];
  assign capture_source_select = st_r.ctrl0[C0_SRC_LSB +: 2];
  assign edge_select_field = st_r.ctrl1[C1_EDGE_LSB +: 2];
  assign capture_input_enable = st_r.ctrl1[C1_CAPTURE_INPUT_ENABLE];
  assign input_filter_enable = st_r.ctrl1[C1_FIL];
  assign filter_sample_clock_select = st_r.ctrl1[C1_NFS];
  assign filter_sample_count_select = st_r.ctrl1[C1_NFT];
  assign capture_auto_clear = st_r.ctrl1[C1_CAPTURE_AUTO_CLEAR];
  assign compare_auto_clear = st_r.ctrl1[C1_CMPCLR];

  // ==========================================================
  // clock enables
  cct_prescaler #(
    .DIV_W(7)
  ) u_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clk_sel_in(counter_clock_select),
    .pwm_period_tick_in(pwm_period_tick_in),
    .count_tick_out(count_tick),
    .fil_tick_out(fil_tick)
  );

  // ==========================================================
  // capture input path; the filter only works while the module is on
  cct_in_filter #(
    .N_SRC(4)
  ) u_fil (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in({external_capture_pin_in, hall_input_c_in, hall_input_b_in, hall_input_a_in}),
    .src_sel_in(capture_source_select),
    .edge_sel_in(edge_select_field),
    .fil_en_in(input_filter_enable & module_on_bit),
    .fil_slow_in(filter_sample_clock_select),
    .fil_long_in(filter_sample_count_select),
    .fil_tick_in(fil_tick),
    .event_out(cap_evt)
  );

  // ==========================================================
  // counter, capture, compare, flags and bus
  always_comb begin
    logic on;
    logic run;
    logic do_cap;
    logic [CNT_W:0] inc;
    logic [IRQ_W-1:0] set;
    logic [IRQ_W-1:0] clr;
    logic wr;
    logic rd;
    logic [7:0] wbyte;
    on = module_on_bit;
    run = 1'b0;
    do_cap = 1'b0;
    inc = '0;
    set = '0;
    clr = '0;
    wr = 1'b0;
    rd = 1'b0;
    wbyte = wb_dat_in[7:0];
    st_nxt = st_r;

    st_nxt.on_d = on;
    run = on && !counter_pause && count_tick;
    do_cap = on && capture_input_enable && cap_evt;
    inc = {1'b0, st_r.cnt} + 1'b1;

    if (do_cap) begin
      st_nxt.cap = st_r.cnt;
      set[IRQ_CAP] = 1'b1;
    end

    if (on && !st_r.on_d) begin
      st_nxt.cnt = CNT_RST;
    end else if (do_cap && capture_auto_clear) begin
      st_nxt.cnt = CNT_RST;
    end else if (run) begin
      st_nxt.cnt = inc[CNT_W-1:0];
      if (inc[CNT_W]) begin
        set[IRQ_OVF] = 1'b1;
      end
      if (inc[CNT_W-1:0] == st_r.cmp) begin
        set[IRQ_CMP] = 1'b1;
        if (compare_auto_clear) begin
          st_nxt.cnt = CNT_RST;
        end
      end
    end
    // when off the counter simply holds its residual value

    // classic wishbone: one ack per request, dropped the cycle after
    st_nxt.ack = 1'b0;
    if (wb_cyc_in && wb_stb_in && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      wr = wb_we_in && wb_sel_in[0];
      rd = !wb_we_in;
    end

    if (wr) begin
      if (hit(wb_adr_in, OFF_CTRL0)) begin
        st_nxt.ctrl0 = wbyte & C0_MASK;
      end
      if (hit(wb_adr_in, OFF_CTRL1)) begin
        st_nxt.ctrl1 = wbyte;
      end
      if (hit(wb_adr_in, OFF_CMP_LO)) begin
        st_nxt.cmp[7:0] = wbyte;
      end
      if (hit(wb_adr_in, OFF_CMP_HI)) begin
        st_nxt.cmp[15:8] = wbyte;
      end
      if (hit(wb_adr_in, OFF_IRQ_EN)) begin
        st_nxt.en = wbyte[IRQ_W-1:0];
      end
      if (hit(wb_adr_in, OFF_IRQ_CLR)) begin
        clr = wbyte[IRQ_W-1:0];
      end
    end

    // an event in the clearing cycle survives: set wins
    st_nxt.stat = (st_r.stat & ~clr) | set;

    if (rd) begin
      st_nxt.dat = '0;
      if (hit(wb_adr_in, OFF_CTRL0)) begin
        st_nxt.dat[7:0] = st_r.ctrl0;
      end
      if (hit(wb_adr_in, OFF_CTRL1)) begin
        st_nxt.dat[7:0] = st_r.ctrl1;
      end
      if (hit(wb_adr_in, OFF_CNT_LO)) begin
        st_nxt.dat[7:0] = st_r.cnt[7:0];
      end
      if (hit(wb_adr_in, OFF_CNT_HI)) begin
        st_nxt.dat[7:0] = st_r.cnt[15:8];
      end
      if (hit(wb_adr_in, OFF_CMP_LO)) begin
        st_nxt.dat[7:0] = st_r.cmp[7:0];
      end
      if (hit(wb_adr_in, OFF_CMP_HI)) begin
        st_nxt.dat[7:0] = st_r.cmp[15:8];
      end
      if (hit(wb_adr_in, OFF_CAP_LO)) begin
        st_nxt.dat[7:0] = st_r.cap[7:0];
      end
      if (hit(wb_adr_in, OFF_CAP_HI)) begin
        st_nxt.dat[7:0] = st_r.cap[15:8];
      end
      if (hit(wb_adr_in, OFF_IRQ_STAT)) begin
        st_nxt.dat[IRQ_W-1:0] = st_r.stat;
      end
      if (hit(wb_adr_in, OFF_IRQ_EN)) begin
        st_nxt.dat[IRQ_W-1:0] = st_r.en;
      end
    end

    st_nxt.irq = |(st_nxt.stat & st_nxt.en);
  end

  // capture pair has no meaningful reset value; zero keeps simulation clean
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r.ctrl0 <= CTRL_RST;
      st_r.ctrl1 <= CTRL_RST;
      st_r.cnt <= CNT_RST;
      st_r.cmp <= CNT_RST;
      st_r.cap <= CAP_RST;
      st_r.stat <= IRQ_RST;
      st_r.en <= IRQ_RST;
      st_r.on_d <= 1'b0;
      st_r.ack <= 1'b0;
      st_r.dat <= '0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_out = st_r.dat;
  assign wb_ack_out = st_r.ack;
  assign irq_out = st_r.irq;

endmodule
`default_nettype wire

// ### testbench/cct_timer_properties.sv
// bus and interrupt port checks of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module cct_timer_properties
  import cct_pkg::*;
#(
  parameter int unsigned ADR_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // bus cycle steps
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_rd(logic [5:0] off);
    s_req ##0 (!wb_we_in && wb_adr_in[7:2] == off[5:2]);
  endsequence
  sequence s_wr(logic [5:0] off);
    s_req ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in[7:2] == off[5:2]);
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_out)
    else $error("request not answered next cycle");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_unasked: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  a_read_narrow: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_write_keeps: assert property (s_req ##0 wb_we_in |=> $stable(wb_dat_out))
    else $error("write disturbed read data");
  a_gap_zero: assert property (s_rd(OFF_CTRL0) |=> !wb_dat_out[2])
    else $error("unused control bit reads one");
  a_stat_width: assert property (s_rd(OFF_IRQ_STAT) |=> wb_dat_out[7:3] == 5'h0)
    else $error("status has extra bits");
  a_unmapped_zero: assert property (s_req ##0 (!wb_we_in && wb_adr_in[7:2] >= OFF_IRQ_CLR[5:2])
    |=> wb_dat_out == 32'h0)
    else $error("write-only or unmapped read not zero");
  a_irq_masked: assert property (s_wr(OFF_IRQ_EN) ##0 wb_dat_in[2:0] == 3'h0 |=> ##1 !irq_out)
    else $error("interrupt high with all sources masked");
endmodule
bind cct_timer cct_timer_properties #(.ADR_W(ADR_W)) cct_timer_properties_i (.clk_in(clk_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .irq_out(irq_out));
`default_nettype wire

// ### testbench/cct_pin_model.sv
// push-pull sensor and capture pin drivers, prompt or one cycle late
`timescale 1ns/1ns
`default_nettype none
module cct_pin_model #(
  parameter int unsigned LAG = 1
) (
  input wire logic clk_in,
  input wire logic [3:0] level_in,
  output logic [3:0] pins_out
);
  logic [3:0] held_r = 4'h0;
  always @(posedge clk_in) begin
    held_r <= level_in;
  end
  assign pins_out = (LAG == 0) ? level_in : held_r;
endmodule
`default_nettype wire

// ### testbench/cct_timer_test.sv
// self-checking bench of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
`define chk(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module cct_timer_test;
  import cct_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic tick = 1'b0;
  logic ack, irq;
  logic [3:0] sel = 4'h1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] dat, rd;
  logic [3:0] lvl = 4'h0;
  logic [3:0] pins;
  logic [31:0] lfsr = 32'haef0;
  logic [2:0] en = 3'h0;
  int n_errors = 0;
  int tests_run = 0;
  int cnt = 0;
  int cap = 0;
  int cmp = 0;
  int stat = 0;
  int c0 = 0;
  int c1 = 0;
  cct_timer cct_timer_i (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(dat), .wb_ack_out(ack),
    .hall_input_a_in(pins[0]), .hall_input_b_in(pins[1]), .hall_input_c_in(pins[2]),
    .external_capture_pin_in(pins[3]), .pwm_period_tick_in(tick), .irq_out(irq));
  cct_pin_model cct_pin_model_i (.clk_in(clk_in), .level_in(lvl), .pins_out(pins));
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic finish_test();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // bus master and reference model
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {2'b00, a};
    wd <= {24'h0, d};
    while (ack !== 1'b1 && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    if (ack !== 1'b1) begin
      n_errors++;
      finish_test();
    end
    rd = dat;
    cyc <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (sel[0]) case (a)
      OFF_CTRL0: begin
        if (d[3] && !c0[3]) cnt = 0;
        c0 = d & C0_MASK;
      end
      OFF_CTRL1: c1 = d;
      OFF_CMP_LO: cmp[7:0] = d;
      OFF_CMP_HI: cmp[15:8] = d;
      OFF_IRQ_EN: en = d[2:0];
      OFF_IRQ_CLR: stat &= ~d;
      default: ;
    endcase
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    `chk(rd, {24'h0, x})
  endtask
  task automatic expect_all();
    rchk(OFF_CNT_LO, cnt[7:0]);
    rchk(OFF_CNT_HI, cnt[15:8]);
    rchk(OFF_CAP_LO, cap[7:0]);
    rchk(OFF_CAP_HI, cap[15:8]);
    rchk(OFF_IRQ_STAT, stat[7:0]);
    `chk(irq, |(stat[2:0] & en))
  endtask
  task automatic pulse(input int n);
    tick <= 1'b1;
    repeat (n) @(posedge clk_in);
    tick <= 1'b0;
    @(posedge clk_in);
    if (c0[3] && !c0[7] && c0[6:4] == 0) count(n);
  endtask
  // model of n counter steps: overflow, compare match and compare clear
  task automatic count(input int n);
    repeat (n) begin
      if (cnt == 65535) stat |= 1;
      cnt = (cnt + 1) % 65536;
      if (cnt == cmp) begin
        stat |= 2;
        if (c1[0]) cnt = 0;
      end
    end
  endtask
  // the divider runs free, so a run of exactly k << s cycles holds k ticks whatever the phase
  task automatic run_div(input int s, input int k);
    wr(OFF_CTRL0, 8'(s * 16 + 136));
    wr(OFF_CTRL0, 8'(s * 16 + 8));
    repeat ((k << s) - 3) @(posedge clk_in);
    wr(OFF_CTRL0, 8'(s * 16 + 136));
    count(k);
  endtask
  // counter is stopped here, so a capture takes a known value
  task automatic edge_to(input int p, input logic v);
    int e;
    e = c1[7:6];
    if (p == c0[1:0] && c0[3] && c1[5] && lvl[p] != v && (e == 3 || e == (v ? 1 : 2))) begin
      cap = cnt;
      stat |= 4;
      if (c1[1]) cnt = 0;
    end
    lvl[p] <= v;
    repeat (40) @(posedge clk_in);
  endtask
  task automatic glitch(input int w);
    lvl[0] <= 1'b1;
    repeat (w) @(posedge clk_in);
    lvl[0] <= 1'b0;
    repeat (40) @(posedge clk_in);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int a = 0; a < 13; a++) rchk(6'(a * 4), 8'h00);
    lfsr = lfsr_next(lfsr);
    wr(OFF_CMP_LO, lfsr[7:0]);
    wr(OFF_CMP_HI, lfsr[15:8]);
    rchk(OFF_CMP_LO, cmp[7:0]);
    rchk(OFF_CMP_HI, cmp[15:8]);
    wr(OFF_CAP_HI, 8'hff);
    wr(OFF_CNT_LO, 8'hff);
    expect_all();
    sel <= 4'h0;
    wr(OFF_CTRL1, 8'hff);
    sel <= 4'h1;
    rchk(OFF_CTRL1, 8'h00);
    wr(OFF_IRQ_EN, 8'h07);
    wr(OFF_CTRL0, 8'h08);
    pulse(lfsr[4:0] + 3);
    expect_all();
    wr(OFF_CTRL0, 8'h8c);
    rchk(OFF_CTRL0, 8'h88);
    pulse(5);
    expect_all();
    wr(OFF_CTRL0, 8'h00);
    pulse(5);
    expect_all();
    wr(OFF_CTRL0, 8'h08);
    expect_all();
    wr(OFF_CMP_LO, 8'h06);
    wr(OFF_CMP_HI, 8'h00);
    wr(OFF_CTRL1, 8'h01);
    pulse(9);
    expect_all();
    wr(OFF_IRQ_CLR, 8'h07);
    expect_all();
    for (int s = 0; s < 4; s++) for (int e = 0; e < 4; e++) begin
      wr(OFF_CTRL0, 8'(s + 8));
      wr(OFF_CTRL1, 8'(e * 64 + 34));
      pulse(s + e + 2);
      edge_to(s, 1'b1);
      edge_to((s + 1) % 4, 1'b1);
      expect_all();
      edge_to(s, 1'b0);
      edge_to((s + 1) % 4, 1'b0);
      expect_all();
    end
    wr(OFF_CTRL0, 8'h08);
    wr(OFF_CTRL1, 8'hc2);
    pulse(4);
    edge_to(0, 1'b1);
    expect_all();
    edge_to(0, 1'b0);
    wr(OFF_IRQ_CLR, 8'h07);
    wr(OFF_CTRL1, 8'hf4);
    glitch(2);
    expect_all();
    wr(OFF_CTRL1, 8'hfc);
    glitch(8);
    expect_all();
    edge_to(0, 1'b1);
    expect_all();
    run_div(1, 5);
    expect_all();
    run_div(7, 2);
    expect_all();
    wr(OFF_CTRL0, 8'h08);
    wr(OFF_CTRL1, 8'h00);
    pulse(65536);
    expect_all();
    wr(OFF_IRQ_EN, 8'h00);
    expect_all();
    finish_test();
  end
endmodule
`default_nettype wire
